// File: design/encoder_defines.vh
// Register map, field positions and reset values of the encoder interface
`ifndef ENCODER_DEFINES_VH
`define ENCODER_DEFINES_VH

// Register offsets
`define ADDR_RAMP_LATCH 8'h36
`define ADDR_MODE 8'h38
`define ADDR_POSITION 8'h39
`define ADDR_CONSTANT 8'h3a
`define ADDR_STATUS 8'h3b
`define ADDR_ENC_LATCH 8'h3c
`define ADDR_IRQ_MASK 8'h3f

// Mode register fields
`define MODE_POL_A 0
`define MODE_POL_B 1
`define MODE_POL_N 2
`define MODE_SKIP_QUAD 3
`define MODE_CONT 4
`define MODE_ONCE 5
`define MODE_EDGE_LO 6
`define MODE_EDGE_HI 7
`define MODE_CLR_ENC 8
`define MODE_LATCH_ACT 9
`define MODE_DECIMAL 10
`define MODE_WIDTH 11

// Event sensitivity codes
`define EDGE_LEVEL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3

// Status fields
`define STAT_N_EVENT 0
`define STAT_WIDTH 2

// Fraction moduli
`define FRAC_BINARY 17'h10000
`define FRAC_DECIMAL 17'h02710

// Reset values
`define RST_MODE 11'h000
`define RST_POSITION 32'h00000000
`define RST_CONSTANT 32'h00010000
`define RST_LATCH 32'h00000000
`define RST_STATUS 2'h0
`define RST_MASK 2'h0

`endif

// File: design/quad_step_decoder.v
// Quadrature A/B synchroniser and step decoder
`timescale 1ns/1ps
`default_nettype none

module quad_step_decoder (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Encoder pins
   input wire enc_a,
   input wire enc_b,
   // Decoded step
   output reg step,
   output reg step_up,
   output reg step_error,
   // Settled channel levels
   output wire a_level,
   output wire b_level
);

   reg [1:0] meta_reg;
   reg [1:0] sync_reg;
   reg [1:0] prev_reg;
   reg init_reg;
   wire a_chg;
   wire b_chg;

   assign a_level = sync_reg[1];
   assign b_level = sync_reg[0];
   assign a_chg = sync_reg[1] ^ prev_reg[1];
   assign b_chg = sync_reg[0] ^ prev_reg[0];

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_reg <= 2'h0;
         sync_reg <= 2'h0;
         prev_reg <= 2'h0;
         init_reg <= 1'b0;
         step <= 1'b0;
         step_up <= 1'b0;
         step_error <= 1'b0;
      end else begin
         meta_reg <= {enc_a, enc_b};
         sync_reg <= meta_reg;
         prev_reg <= sync_reg;
         init_reg <= 1'b1;
         // One channel changed: a step; both: a lost step, dropped
         step <= init_reg & (a_chg ^ b_chg);
         step_up <= ~(prev_reg[1] ^ sync_reg[0]);
         step_error <= init_reg & a_chg & b_chg;
      end
   end

endmodule

`default_nettype wire

// File: design/encoder_interface.v
// Incremental encoder interface: position accumulator and index latch
`timescale 1ns/1ps
`default_nettype none
`include "encoder_defines.vh"

module encoder_interface (
   // Clock and reset
   input wire clk,
   input wire reset_n,
   // Register port
   input wire [7:0] addr,
   input wire [31:0] wr_data,
   input wire wr_en,
   input wire rd_en,
   output reg [31:0] rd_data,
   // Encoder pins
   input wire enc_a,
   input wire enc_b,
   input wire enc_n,
   // Ramp generator
   input wire [31:0] ramp_actual_position,
   // Events
   output wire irq,
   output reg index_latched
);

   // Mode and data registers
   reg [`MODE_WIDTH-1:0] mode_reg;
   reg [31:0] position_reg;
   reg [31:0] position_next;
   reg [16:0] frac_reg;
   reg [16:0] frac_next;
   reg [31:0] constant_reg;
   reg [31:0] enc_latch_reg;
   reg [31:0] ramp_latch_reg;
   reg [`STAT_WIDTH-1:0] status_reg;
   reg [`STAT_WIDTH-1:0] status_next;
   reg [`STAT_WIDTH-1:0] mask_reg;
   reg once_armed_reg;

   // Index channel synchroniser
   reg n_meta_reg;
   reg n_sync_reg;
   reg n_active_prev_reg;

   // Decoder outputs
   wire step;
   wire step_up;
   wire step_error;
   wire a_level;
   wire b_level;

   // Index qualification
   wire n_active;
   wire quad_ok;
   reg index_event;
   wire do_latch;

   // Accumulator scratch
   reg [16:0] modulus;
   reg [17:0] frac_sum;
   reg carry;
   reg [31:0] int_step;

   // Register port decode
   wire wr_mode;
   wire wr_position;
   wire wr_constant;
   wire wr_status;
   wire wr_mask;
   wire rd_status;

   // Strobe qualified by an address match
   function reg_hit;
      input strobe;
      input [7:0] a;
      input [7:0] offset;
      begin
         reg_hit = strobe & (a == offset);
      end
   endfunction

   assign wr_mode = reg_hit(wr_en, addr, `ADDR_MODE);
   assign wr_position = reg_hit(wr_en, addr, `ADDR_POSITION);
   assign wr_constant = reg_hit(wr_en, addr, `ADDR_CONSTANT);
   assign wr_status = reg_hit(wr_en, addr, `ADDR_STATUS);
   assign wr_mask = reg_hit(wr_en, addr, `ADDR_IRQ_MASK);
   assign rd_status = reg_hit(rd_en, addr, `ADDR_STATUS);

   quad_step_decoder u_decoder (
      .clk(clk),
      .reset_n(reset_n),
      .enc_a(enc_a),
      .enc_b(enc_b),
      .step(step),
      .step_up(step_up),
      .step_error(step_error),
      .a_level(a_level),
      .b_level(b_level)
   );

   // Index synchroniser, first stage read only by the second
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         n_meta_reg <= 1'b0;
         n_sync_reg <= 1'b0;
      end else begin
         n_meta_reg <= enc_n;
         n_sync_reg <= n_meta_reg;
      end
   end

   assign n_active = mode_reg[`MODE_POL_N] ? n_sync_reg : ~n_sync_reg;
   assign quad_ok = mode_reg[`MODE_SKIP_QUAD] |
      ((a_level == mode_reg[`MODE_POL_A]) &
      (b_level == mode_reg[`MODE_POL_B]));

   always @* begin
      case (mode_reg[`MODE_EDGE_HI:`MODE_EDGE_LO])
         `EDGE_LEVEL: index_event = n_active;
         `EDGE_RISE: index_event = n_active & ~n_active_prev_reg;
         `EDGE_FALL: index_event = ~n_active & n_active_prev_reg;
         `EDGE_BOTH: index_event = n_active ^ n_active_prev_reg;
         default: index_event = 1'b0;
      endcase
      index_event = index_event & quad_ok;
   end

   // Latch when continuous, or once after an arming write
   assign do_latch = index_event &
      (mode_reg[`MODE_CONT] | once_armed_reg);

   // Fractional accumulation with selectable modulus
   always @* begin
      modulus = mode_reg[`MODE_DECIMAL] ? `FRAC_DECIMAL : `FRAC_BINARY;
      frac_sum = 18'h00000;
      carry = 1'b0;
      int_step = {{16{constant_reg[31]}}, constant_reg[31:16]};
      frac_next = frac_reg;
      position_next = position_reg;
      if (step) begin
         if (step_up) begin
            frac_sum = {1'b0, frac_reg} + {2'h0, constant_reg[15:0]};
            if (frac_sum >= {1'b0, modulus}) begin
               frac_sum = frac_sum - {1'b0, modulus};
               carry = 1'b1;
            end
            frac_next = frac_sum[16:0];
            position_next = position_reg + int_step + {31'h0, carry};
         end else begin
            frac_sum = {1'b0, frac_reg} - {2'h0, constant_reg[15:0]};
            if (frac_sum[17]) begin
               frac_sum = frac_sum + {1'b0, modulus};
               carry = 1'b1;
            end
            frac_next = frac_sum[16:0];
            position_next = position_reg - int_step - {31'h0, carry};
         end
      end
      if (do_latch && mode_reg[`MODE_CLR_ENC]) begin
         position_next = 32'h00000000;
         frac_next = 17'h00000;
      end
      if (wr_position) begin
         position_next = wr_data;
         frac_next = 17'h00000;
      end
   end

   // Status: hardware set wins over read or write-one clear
   always @* begin
      status_next = status_reg;
      if (rd_status)
         status_next = {`STAT_WIDTH{1'b0}};
      if (wr_status)
         status_next = status_next & ~wr_data[`STAT_WIDTH-1:0];
      if (index_event)
         status_next[`STAT_N_EVENT] = 1'b1;
   end

   assign irq = |(status_reg & mask_reg);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_reg <= `RST_MODE;
         position_reg <= `RST_POSITION;
         frac_reg <= 17'h00000;
         constant_reg <= `RST_CONSTANT;
         enc_latch_reg <= `RST_LATCH;
         ramp_latch_reg <= `RST_LATCH;
         status_reg <= `RST_STATUS;
         mask_reg <= `RST_MASK;
         once_armed_reg <= 1'b0;
         n_active_prev_reg <= 1'b0;
         index_latched <= 1'b0;
      end else begin
         n_active_prev_reg <= n_active;
         position_reg <= position_next;
         frac_reg <= frac_next;
         status_reg <= status_next;
         index_latched <= do_latch;
         if (do_latch) begin
            enc_latch_reg <= position_reg;
            if (mode_reg[`MODE_LATCH_ACT])
               ramp_latch_reg <= ramp_actual_position;
         end
         if (wr_mode) begin
            mode_reg <= wr_data[`MODE_WIDTH-1:0];
            once_armed_reg <= wr_data[`MODE_ONCE];
         end else if (do_latch) begin
            once_armed_reg <= 1'b0;
         end
         if (wr_constant)
            constant_reg <= wr_data;
         if (wr_mask)
            mask_reg <= wr_data[`STAT_WIDTH-1:0];
      end
   end

   // Read data, valid the cycle after the read strobe
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_data <= 32'h00000000;
      end else if (rd_en) begin
         case (addr)
            `ADDR_MODE: rd_data <= {21'h000000, mode_reg};
            `ADDR_POSITION: rd_data <= position_reg;
            `ADDR_CONSTANT: rd_data <= constant_reg;
            `ADDR_STATUS: rd_data <= {30'h00000000, status_reg};
            `ADDR_ENC_LATCH: rd_data <= enc_latch_reg;
            `ADDR_RAMP_LATCH: rd_data <= ramp_latch_reg;
            `ADDR_IRQ_MASK: rd_data <= {30'h00000000, mask_reg};
            default: rd_data <= 32'h00000000;
         endcase
      end else begin
         rd_data <= 32'h00000000;
      end
   end

endmodule

`default_nettype wire

// File: dv/enc_if_chk_asserts.sv
// Port checker of the encoder interface
`timescale 1ns/1ps
`default_nettype none
module enc_if_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [31:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [31:0] rd_data,
   // Pins and events
   input wire logic enc_a,
   input wire logic enc_b,
   input wire logic irq,
   input wire logic index_latched
);
   logic [1:0] mask_q;
   logic once_q;
   logic cont_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   // Shadow of mask and latch options
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mask_q <= 2'h0;
         once_q <= 1'b0;
         cont_q <= 1'b0;
      end else if (wr_en && addr == 8'h38) begin
         once_q <= wr_data[5];
         cont_q <= wr_data[4];
      end else if (wr_en && addr == 8'h3f)
         mask_q <= wr_data[1:0];
      else if (index_latched)
         once_q <= 1'b0;
   end
   sequence s_wr_rd(a);
      wr_en && addr == a ##2 rd_en && addr == a;
   endsequence
   sequence s_quiet;
      ($stable(enc_a) && $stable(enc_b))[*7];
   endsequence
   property p_rd_idle; !$past(rd_en) |-> rd_data == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("stray read data");
   property p_mode_rw;
      s_wr_rd(8'h38) |=> rd_data == ($past(wr_data, 3) & 32'h7ff);
   endproperty
   a_mode_rw: assert property (p_mode_rw)
      else $error("mode readback wrong");
   property p_const_rw; s_wr_rd(8'h3a) |=> rd_data == $past(wr_data, 3);
   endproperty
   a_const_rw: assert property (p_const_rw)
      else $error("constant readback wrong");
   property p_pos_rw;
      s_quiet ##0 !cont_q && !once_q ##0 s_wr_rd(8'h39)
         |=> rd_data == $past(wr_data, 3);
   endproperty
   a_pos_rw: assert property (p_pos_rw)
      else $error("position readback wrong");
   property p_stat_hi; rd_en && addr == 8'h3b |=> !rd_data[1]; endproperty
   a_stat_hi: assert property (p_stat_hi)
      else $error("status bit 1 set");
   property p_arm; index_latched && !$past(wr_en) |-> cont_q || once_q;
   endproperty
   a_arm: assert property (p_arm)
      else $error("latch without option");
   property p_irq_off; mask_q == 2'h0 |-> !irq; endproperty
   a_irq_off: assert property (p_irq_off)
      else $error("irq while masked");
   property p_irq_on; index_latched && mask_q[0] |-> irq; endproperty
   a_irq_on: assert property (p_irq_on)
      else $error("irq missing");
endmodule
bind encoder_interface enc_if_chk u_chk (.clk, .reset_n, .addr, .wr_data,
   .wr_en, .rd_en, .rd_data, .enc_a, .enc_b, .irq, .index_latched);
`default_nettype wire

// File: dv/quad_encoder_model.sv
// Quadrature encoder model with A, B and index channels
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
   // Clock
   input wire logic clk,
   // Encoder pins
   output logic enc_a,
   output logic enc_b,
   output logic enc_n
);
   logic [1:0] ph = 2'h0;
   initial begin
      enc_a = 1'b0;
      enc_b = 1'b0;
      enc_n = 1'b0;
   end
   // Inc 1 forward, 3 reverse, 2 jumps a state
   task automatic move(input logic [1:0] inc, input int n, input int hold);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         ph = ph + inc;
         enc_a <= ph[0] ^ ph[1];
         enc_b <= ph[1];
         repeat (hold) @(posedge clk);
      end
   endtask
   task automatic index(input logic lvl, input int len);
      @(posedge clk);
      enc_n <= lvl;
      repeat (len) @(posedge clk);
      enc_n <= !lvl;
   endtask
   task automatic park(input logic lvl);
      @(posedge clk);
      enc_n <= lvl;
   endtask
endmodule
`default_nettype wire

// File: dv/tb_encoder_interface.sv
// Self-checking bench of the encoder interface
`timescale 1ns/1ps
`default_nettype none
module tb_encoder_interface;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [7:0] addr = 8'h0;
   logic [31:0] wr_data = 32'h0;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] ramp = 32'h0;
   logic rd_q = 1'b0;
   logic [31:0] seed = 32'hf1ac4870;
   logic [31:0] exp_q[$];
   wire [31:0] rd_data;
   wire enc_a, enc_b, enc_n, irq, index_latched;
   int fails = 0;
   int tests_run = 0;
   int lat_cnt = 0;
   logic [7:0] ra[8] = '{8'h36, 8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h3f,
      8'h3d};
   logic [11:0] lm[4] = '{12'h357, 12'h355, 12'h35d, 12'h05d};
   logic [7:0] em[9] = '{8'h1c, 8'h5c, 8'h9c, 8'hdc, 8'h2c, 8'h6c, 8'h0c,
      8'h58, 8'h18};
   int en[9] = '{8, 2, 2, 4, 1, 1, 0, 2, 8};
   always #2.5 clk = ~clk;
   encoder_interface dut (.clk, .reset_n, .addr, .wr_data, .wr_en, .rd_en,
      .rd_data, .enc_a, .enc_b, .enc_n, .ramp_actual_position(ramp), .irq,
      .index_latched);
   quad_encoder_model enc (.clk, .enc_a, .enc_b, .enc_n);
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d);
      exp_q.push_back(d);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
   endtask
   task automatic finish_test();
      $display("fails %0d tests_run %0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Read data stands only in the cycle after the strobe
   always @(posedge clk) begin
      if (rd_q)
         chk(rd_data, exp_q.pop_front());
      rd_q <= rd_en;
      if (index_latched)
         lat_cnt++;
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      finish_test();
   end
   initial begin
      logic [31:0] p;
      logic [31:0] r;
      logic [31:0] lp;
      logic [31:0] rp;
      logic hit;
      lp = 32'h0;
      rp = 32'h0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      foreach (ra[i])
         rd(ra[i], ra[i] == 8'h3a ? 32'h10000 : {31'h0, ra[i] == 8'h3b});
      p = rnd();
      wr(8'h3a, p);
      rd(8'h3a, p);
      p = (rnd() & 32'hffffffcf) | 32'h4;
      wr(8'h38, p);
      rd(8'h38, p & 32'h7ff);
      wr(8'h38, 32'h4);
      p = rnd();
      wr(8'h39, p);
      rd(8'h39, p);
      wr(8'h3a, 32'h18000);
      wr(8'h39, 32'h0);
      enc.move(2'h1, 3, 3);
      enc.move(2'h3, 1, 3);
      enc.move(2'h2, 1, 3);
      repeat (8) @(posedge clk);
      rd(8'h39, 32'h3);
      wr(8'h38, 32'h404);
      wr(8'h3a, 32'h7fff270f);
      wr(8'h39, 32'h0);
      enc.move(2'h1, 2, 3);
      repeat (8) @(posedge clk);
      rd(8'h39, 32'hffff);
      foreach (lm[i]) begin
         p = rnd();
         r = rnd();
         ramp <= r;
         wr(8'h39, p);
         wr(8'h38, {20'h0, lm[i]});
         lat_cnt = 0;
         enc.index(1'b1, 3);
         repeat (8) @(posedge clk);
         hit = lm[i] != 12'h355;
         if (hit)
            lp = p;
         if (hit && lm[i][9])
            rp = r;
         chk(lat_cnt, {31'h0, hit});
         rd(8'h3c, lp);
         rd(8'h39, hit && lm[i][8] ? 32'h0 : p);
         rd(8'h36, rp);
         rd(8'h3b, {31'h0, hit});
      end
      foreach (em[i]) begin
         enc.park(!em[i][2]);
         repeat (6) @(posedge clk);
         wr(8'h38, {24'h0, em[i]});
         lat_cnt = 0;
         repeat (2) begin
            enc.index(em[i][2], 4);
            repeat (10) @(posedge clk);
         end
         chk(lat_cnt, en[i]);
      end
      enc.park(1'b0);
      repeat (6) @(posedge clk);
      wr(8'h38, 32'h1c);
      wr(8'h3b, 32'h1);
      rd(8'h3b, 32'h0);
      enc.index(1'b1, 2);
      repeat (8) @(posedge clk);
      chk(irq, 32'h0);
      wr(8'h3f, 32'h1);
      @(negedge clk);
      chk(irq, 32'h1);
      rd(8'h3f, 32'h1);
      rd(8'h3b, 32'h1);
      @(negedge clk);
      chk(irq, 32'h0);
      enc.index(1'b1, 2);
      repeat (8) @(posedge clk);
      wr(8'h3b, 32'h1);
      @(negedge clk);
      chk(irq, 32'h0);
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule
`default_nettype wire
